// ### hdl/udr_pkg.sv
// Purpose: Shared constants and helpers for the DMA ring-buffer serial port.
// Assumes: One system clock; register words are 16 bits wide.
// Notes:   Offsets are word indices on the plain register port.
package udr_pkg;
  // ==========================================================================
  // Clock and baud timing
  localparam int unsigned SYS_CLK_HZ     = 25_000_000;
  localparam int unsigned OVERSAMPLE     = 16;
  localparam logic [3:0]  BAUD_CODE_RST  = 4'h9;
  localparam logic [3:0]  TICK_LAST      = 4'hf;
  localparam logic [3:0]  TICK_MID       = 4'h7;
  localparam int unsigned DIV_W          = 16;

  // ==========================================================================
  // Buffers
  localparam int unsigned DEPTH          = 16;
  localparam int unsigned PTR_W          = 4;
  localparam logic [3:0]  LEN_LAST_RST   = 4'hf;

  // ==========================================================================
  // Register offsets
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_ILEN    = 4'h1;
  localparam logic [3:0] REG_OLEN    = 4'h2;
  localparam logic [3:0] REG_RXDATA  = 4'h3;
  localparam logic [3:0] REG_RXCOUNT = 4'h4;
  localparam logic [3:0] REG_TXDATA  = 4'h5;
  localparam logic [3:0] REG_STATUS  = 4'h6;
  localparam logic [3:0] REG_ISTAT   = 4'h7;
  localparam logic [3:0] REG_IMASK   = 4'h8;
  localparam logic [3:0] REG_TXGO    = 4'h9;
  localparam logic [3:0] REG_FLUSH   = 4'ha;

  // ==========================================================================
  // Control fields and reset values
  localparam int unsigned CTL_EN     = 0;
  localparam int unsigned CTL_BAUD   = 1;
  localparam int unsigned CTL_SEVEN  = 5;
  localparam int unsigned CTL_TWOSTP = 6;
  localparam int unsigned CTL_PAREN  = 7;
  localparam int unsigned CTL_PARODD = 8;
  localparam logic [8:0]  CTRL_RST   = 9'h012;

  // Interrupt status bits.
  localparam int unsigned IRQ_RX    = 0;
  localparam int unsigned IRQ_TXDN  = 1;
  localparam int unsigned IRQ_PERR  = 2;
  localparam int unsigned IRQ_FERR  = 3;
  localparam int unsigned IRQ_W     = 4;

  // Baud rate in bits per second for each select code.
  function automatic int unsigned udr_baud_of(input logic [3:0] code);
    unique case (code)
      4'h1: udr_baud_of = 110;
      4'h2: udr_baud_of = 150;
      4'h3: udr_baud_of = 300;
      4'h4: udr_baud_of = 600;
      4'h5: udr_baud_of = 1200;
      4'h6: udr_baud_of = 2400;
      4'h7: udr_baud_of = 4800;
      4'h8: udr_baud_of = 9600;
      4'h9: udr_baud_of = 19200;
      4'ha: udr_baud_of = 38400;
      4'hb: udr_baud_of = 57600;
      4'hc: udr_baud_of = 115200;
      4'hd: udr_baud_of = 250000;
      4'he: udr_baud_of = 500000;
      4'hf: udr_baud_of = 1250000;
      default: udr_baud_of = 19200;
    endcase
  endfunction : udr_baud_of

  // Divisor of the sixteenth-rate clock, rounded, never below one.
  function automatic logic [15:0] udr_div_of(input logic [3:0] code);
    int unsigned d;
    d = (SYS_CLK_HZ + (OVERSAMPLE * udr_baud_of(code)) / 2)
        / (OVERSAMPLE * udr_baud_of(code));
    if (d < 1) d = 1;
    udr_div_of = d[15:0];
  endfunction : udr_div_of

  // Ring pointer step that wraps after the configured last index.
  function automatic logic [3:0] udr_step(input logic [3:0] p,
                                          input logic [3:0] last);
    udr_step = (p >= last) ? 4'h0 : p + 4'h1;
  endfunction : udr_step
endpackage : udr_pkg

// ### hdl/udr_port.sv
// Purpose: One full-duplex serial port with receive ring and transmit ring.
// Assumes: Register port strobes are one cycle long and never both at once.
// Notes:   Two ports are built by instantiating this module twice.
//
// Notes on behaviour
// - Bit timing comes from the system clock and never runs faster than a sixteenth of it.
// - The bit rate is the sixteenth-rate clock divided by a divisor chosen by the code.
// - Baud codes 1 to 15 run from 110 to 1,250,000 baud, and code 9 (19,200) is the default.
// - Once enabled the port sends and receives at the same time, independently.
// - The frame defaults to 8 data bits, 1 stop bit, no parity, and the control word changes it.
// - Each received byte is stored into the input ring with no software action.
// - A full input ring keeps receiving and drops its oldest byte silently.
// - The receive count gives the unread distance from read pointer to write pointer.
// - Reading receive data returns the oldest byte and moves the read pointer by one.
// - Reception runs until reset or until software closes the port.
// - The receiver needs no request-to-send output to pause the sender.
// - Software may add transmit bytes at any time, even while sending.
// - A transmit service that finds head equal to tail turns the transmit service off.
// - While the transmit ring holds data the next byte is taken and sent.
// - The busy flag drops once all queued transmit data has gone out.
// - Every instance of the port behaves the same.
`timescale 1ns/1ps
module udr_port import udr_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        rxd,
  output logic             txd,
  output logic             irq
);
  // ==========================================================================
  // Declarations
  logic [8:0]       ctrl;
  logic [3:0]       ilast;
  logic [3:0]       olast;
  logic [7:0]       ibuf [DEPTH];
  logic [7:0]       obuf [DEPTH];
  logic [3:0]       iwr;
  logic [3:0]       ird;
  logic [4:0]       icnt;
  logic [3:0]       ohead;
  logic [3:0]       otail;
  logic             tx_svc_en;
  logic             tx_load;
  logic [7:0]       tx_byte;
  logic             tx_active;
  logic             tx_busy;
  logic             txd_int;
  logic [IRQ_W-1:0] istat;
  logic [IRQ_W-1:0] imask;
  logic [IRQ_W-1:0] iset;
  logic [15:0]      div_cnt;
  logic [15:0]      div_val;
  logic             tick;
  logic             rxd_meta;
  logic             rxd_sync;
  logic             rx_valid;
  logic [7:0]       rx_data;
  logic             rx_perr;
  logic             rx_ferr;
  logic             tx_done;
  logic             port_en;
  logic             wr_hit_ctrl;
  logic             rd_rx;
  logic             rx_take;
  logic             wr_tx;
  logic             flush;
  logic [3:0]       baud_code;

  assign port_en   = ctrl[CTL_EN];
  assign baud_code = ctrl[CTL_BAUD +: 4];
  assign wr_hit_ctrl = reg_wr && (reg_addr == REG_CTRL);
  assign rd_rx     = reg_rd && (reg_addr == REG_RXDATA);
  assign rx_take   = rd_rx && (icnt != 5'h00);
  assign wr_tx     = reg_wr && (reg_addr == REG_TXDATA);
  assign flush     = reg_wr && (reg_addr == REG_FLUSH);
  assign txd       = txd_int;

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl  <= CTRL_RST;
      ilast <= LEN_LAST_RST;
      olast <= LEN_LAST_RST;
    end else if (reg_wr) begin
      if (wr_hit_ctrl) begin
        ctrl <= reg_wdata[8:0];
        if (reg_wdata[CTL_BAUD +: 4] == 4'h0) begin
          ctrl[CTL_BAUD +: 4] <= BAUD_CODE_RST;
        end
      end
      if (reg_addr == REG_ILEN) ilast <= reg_wdata[3:0];
      if (reg_addr == REG_OLEN) olast <= reg_wdata[3:0];
    end
  end

  // ==========================================================================
  // Baud divider
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_val <= 16'h0001;
    end else begin
      div_val <= udr_div_of(baud_code);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (!port_en || wr_hit_ctrl) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (div_cnt + 16'h0001 >= div_val) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  // ==========================================================================
  // Receive pin synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
    end
  end

  // ==========================================================================
  // Serial engines
  udr_rx u_rx (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .en      (port_en),
    .tick    (tick),
    .rxd     (rxd_sync),
    .seven   (ctrl[CTL_SEVEN]),
    .par_en  (ctrl[CTL_PAREN]),
    .par_odd (ctrl[CTL_PARODD]),
    .valid   (rx_valid),
    .data    (rx_data),
    .par_err (rx_perr),
    .frm_err (rx_ferr)
  );

  udr_tx u_tx (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .tick     (tick),
    .start    (tx_load),
    .data     (tx_byte),
    .seven    (ctrl[CTL_SEVEN]),
    .two_stop (ctrl[CTL_TWOSTP]),
    .par_en   (ctrl[CTL_PAREN]),
    .par_odd  (ctrl[CTL_PARODD]),
    .busy     (tx_busy),
    .txd      (txd_int)
  );

  // ==========================================================================
  // Input ring, written by the receive channel
  always_ff @(posedge sys_clk) begin
    if (rx_valid) ibuf[iwr] <= rx_data;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      iwr  <= 4'h0;
      ird  <= 4'h0;
      icnt <= 5'h00;
    end else if (flush) begin
      iwr  <= 4'h0;
      ird  <= 4'h0;
      icnt <= 5'h00;
    end else begin
      if (rx_valid) begin
        iwr <= udr_step(iwr, ilast);
      end
      if (rx_valid && (icnt == {1'b0, ilast} + 5'h01)) begin
        ird <= udr_step(ird, ilast);
      end else if (rx_take) begin
        ird <= udr_step(ird, ilast);
      end
      if (rx_valid && !rx_take && (icnt != {1'b0, ilast} + 5'h01)) begin
        icnt <= icnt + 5'h01;
      end else if (!rx_valid && rx_take) begin
        icnt <= icnt - 5'h01;
      end
    end
  end

  // ==========================================================================
  // Output ring and transmit service
  always_ff @(posedge sys_clk) begin
    if (wr_tx) obuf[ohead] <= reg_wdata[7:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ohead <= 4'h0;
    end else if (wr_tx) begin
      ohead <= udr_step(ohead, olast);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      otail     <= 4'h0;
      tx_svc_en <= 1'b0;
      tx_load   <= 1'b0;
      tx_byte   <= 8'h00;
    end else begin
      tx_load <= 1'b0;
      if (reg_wr && (reg_addr == REG_TXGO)) begin
        tx_svc_en <= reg_wdata[0];
      end else if (!port_en) begin
        tx_svc_en <= 1'b0;
      end else if (tx_svc_en && !tx_busy && !tx_load) begin
        if (ohead == otail) begin
          tx_svc_en <= 1'b0;
        end else begin
          tx_byte <= obuf[otail];
          tx_load <= 1'b1;
          otail   <= udr_step(otail, olast);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_active <= 1'b0;
      tx_done   <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (tx_load) begin
        tx_active <= 1'b1;
      end else if (tx_active && !tx_busy && (ohead == otail)) begin
        tx_active <= 1'b0;
        tx_done   <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Interrupt status, mask and output
  assign iset = {rx_valid & rx_ferr, rx_valid & rx_perr, tx_done, rx_valid};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat <= '0;
    end else if (reg_wr && (reg_addr == REG_ISTAT)) begin
      istat <= (istat & ~reg_wdata[IRQ_W-1:0]) | iset;
    end else begin
      istat <= istat | iset;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      imask <= '0;
    end else if (reg_wr && (reg_addr == REG_IMASK)) begin
      imask <= reg_wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat & imask);
    end
  end

  // ==========================================================================
  // Register read port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:    reg_rdata <= {7'h00, ctrl};
        REG_ILEN:    reg_rdata <= {12'h000, ilast};
        REG_OLEN:    reg_rdata <= {12'h000, olast};
        REG_RXDATA:  reg_rdata <= rx_take ? {8'h00, ibuf[ird]} : 16'h0000;
        REG_RXCOUNT: reg_rdata <= {11'h000, icnt};
        REG_STATUS:  reg_rdata <= {4'h0, otail, ohead, 1'b0, tx_busy,
                                   tx_svc_en, tx_active};
        REG_ISTAT:   reg_rdata <= {12'h000, istat};
        REG_IMASK:   reg_rdata <= {12'h000, imask};
        default:     reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule : udr_port

// ### hdl/udr_rx.sv
// Purpose: Serial receiver sampling mid-bit on a sixteen-times enable.
// Assumes: rxd is already synchronised to sys_clk.
// Notes:   Held idle while en is low.
`timescale 1ns/1ps
module udr_rx import udr_pkg::*; (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       en,
  input  wire logic       tick,
  input  wire logic       rxd,
  input  wire logic       seven,
  input  wire logic       par_en,
  input  wire logic       par_odd,
  output logic            valid,
  output logic [7:0]      data,
  output logic            par_err,
  output logic            frm_err
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} udr_rx_st_t;
  udr_rx_st_t state;
  logic [3:0] tcnt;
  logic [2:0] bitn;
  logic [7:0] shreg;
  logic       pbad;

  // ==========================================================================
  // Bit sampler
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= RX_IDLE;
      tcnt    <= 4'h0;
      bitn    <= 3'h0;
      shreg   <= 8'h00;
      pbad    <= 1'b0;
      valid   <= 1'b0;
      data    <= 8'h00;
      par_err <= 1'b0;
      frm_err <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (!en) begin
        state <= RX_IDLE;
      end else if (state == RX_IDLE) begin
        if (!rxd) begin
          state <= RX_START;
          tcnt  <= 4'h0;
        end
      end else if (tick) begin
        tcnt <= tcnt + 4'h1;
        unique case (state)
          RX_START: if (tcnt == TICK_MID) begin
            state <= rxd ? RX_IDLE : RX_DATA;
            tcnt  <= 4'h0;
            bitn  <= 3'h0;
          end
          RX_DATA: if (tcnt == TICK_LAST) begin
            shreg <= {rxd, shreg[7:1]};
            bitn  <= bitn + 3'h1;
            if (bitn == {2'h3, ~seven}) state <= par_en ? RX_PAR : RX_STOP;
          end
          RX_PAR: if (tcnt == TICK_LAST) begin
            pbad  <= (^(shreg & {7'h7f, ~seven}) ^ rxd) != par_odd;
            state <= RX_STOP;
          end
          RX_STOP: if (tcnt == TICK_LAST) begin
            state   <= RX_IDLE;
            valid   <= 1'b1;
            data    <= seven ? {1'b0, shreg[7:1]} : shreg;
            par_err <= par_en & pbad;
            frm_err <= ~rxd;
            pbad    <= 1'b0;
          end
          default: state <= RX_IDLE;
        endcase
      end
    end
  end
endmodule : udr_rx

// ### hdl/udr_tx.sv
// Purpose: Serial transmitter driven by a sixteen-times bit-rate enable.
// Assumes: start is taken only while busy is low.
// Notes:   Frame is start, 7 or 8 data bits LSB first, optional parity, stops.
`timescale 1ns/1ps
module udr_tx import udr_pkg::*; (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic [7:0] data,
  input  wire logic       seven,
  input  wire logic       two_stop,
  input  wire logic       par_en,
  input  wire logic       par_odd,
  output logic            busy,
  output logic            txd
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} udr_tx_st_t;
  udr_tx_st_t state;
  logic [3:0] tcnt;
  logic [2:0] bitn;
  logic [7:0] shreg;
  logic       par;
  logic       stop2;

  // ==========================================================================
  // Bit sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TX_IDLE;
      tcnt  <= 4'h0;
      bitn  <= 3'h0;
      shreg <= 8'h00;
      par   <= 1'b0;
      stop2 <= 1'b0;
      busy  <= 1'b0;
      txd   <= 1'b1;
    end else if (state == TX_IDLE) begin
      if (start) begin
        state <= TX_START;
        shreg <= data;
        par   <= ^(data & {~seven, 7'h7f}) ^ par_odd;
        stop2 <= two_stop;
        tcnt  <= 4'h0;
        busy  <= 1'b1;
        txd   <= 1'b0;
      end
    end else if (tick) begin
      tcnt <= tcnt + 4'h1;
      if (tcnt == TICK_LAST) begin
        unique case (state)
          TX_START: begin
            state <= TX_DATA;
            bitn  <= 3'h0;
            txd   <= shreg[0];
          end
          TX_DATA: begin
            shreg <= {1'b0, shreg[7:1]};
            bitn  <= bitn + 3'h1;
            if (bitn == {2'h3, ~seven}) begin
              state <= par_en ? TX_PAR : TX_STOP;
              txd   <= par_en ? par : 1'b1;
            end else begin
              txd <= shreg[1];
            end
          end
          TX_PAR: begin
            state <= TX_STOP;
            txd   <= 1'b1;
          end
          TX_STOP: begin
            if (stop2) begin
              stop2 <= 1'b0;
            end else begin
              state <= TX_IDLE;
              busy  <= 1'b0;
            end
          end
          default: state <= TX_IDLE;
        endcase
      end
    end
  end
endmodule : udr_tx

// ### test/uart_dma_ring_buffer_port_tb_top.sv
// Purpose: Self-checking bench for one ring-buffer serial port.
// Assumes: Baud code 15 gives sixteen clocks a bit.
// Notes:   The peer model plays the remote device.
`timescale 1ns/1ps
module uart_dma_ring_buffer_port_tb_top import udr_pkg::*;;
  logic        sys_clk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        rxd;
  logic        txd;
  logic        irq;
  int          miscompares;
  int          samples_checked;
  logic [15:0] d;

  udr_port DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd), .irq(irq));
  udr_serial_peer #(.BIT_CYC(16)) peer (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ==========================================================================
  // Shared tasks.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic expect_rd(input string what, input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    check(what, v, exp);
  endtask : expect_rd
  task automatic expect_tx(input logic [7:0] b, input logic s);
    int k;
    k = 0;
    while (peer.got_q.size() == 0 && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
    check("tx frame", (peer.got_q.size() > 0) ? {7'h00, peer.got_q.pop_front()} : 16'hdead,
          {7'h00, s, b});
  endtask : expect_tx
  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    expect_rd("ctrl", REG_CTRL, 16'h0012);
    expect_rd("ilen", REG_ILEN, 16'h000f);
    expect_rd("rx count", REG_RXCOUNT, 16'h0000);
    expect_rd("empty pop", REG_RXDATA, 16'h0000);
    wr(4'hb, 16'hffff);
    expect_rd("unmapped", 4'hb, 16'h0000);
    for (int c = 0; c < 16; c++) begin
      wr(REG_CTRL, {11'h000, c[3:0], 1'b0});
      expect_rd("baud code", REG_CTRL, {11'h000, (c == 0) ? 4'h9 : c[3:0], 1'b0});
    end
    $display("test reset done");
  endtask : t_reset
  task automatic t_tx();
    wr(REG_CTRL, 16'h001f);
    wr(REG_IMASK, 16'h0002);
    for (int i = 0; i < 3; i++) wr(REG_TXDATA, 16'h00a0 + 16'(i));
    wr(REG_TXGO, 16'h0001);
    repeat (40) @(posedge sys_clk);
    wr(REG_TXDATA, 16'h00a3);
    rd(REG_STATUS, d);
    check("busy", {15'h0000, d[0]}, 16'h0001);
    for (int i = 0; i < 4; i++) expect_tx(8'ha0 + 8'(i), 1'b1);
    repeat (30) @(posedge sys_clk);
    rd(REG_STATUS, d);
    check("service off", {14'h0000, d[1:0]}, 16'h0000);
    check("irq done", {15'h0000, irq}, 16'h0001);
    wr(REG_ISTAT, 16'h000f);
    repeat (3) @(posedge sys_clk);
    check("irq clear", {15'h0000, irq}, 16'h0000);
    wr(REG_IMASK, 16'h0000);
    $display("test tx done");
  endtask : t_tx
  task automatic t_rx();
    logic [7:0] b[3];
    b = '{8'h5a, 8'hc3, 8'h01};
    wr(REG_FLUSH, 16'h0001);
    for (int i = 0; i < 3; i++) peer.send_byte(b[i]);
    repeat (40) @(posedge sys_clk);
    expect_rd("rx count", REG_RXCOUNT, 16'h0003);
    for (int i = 0; i < 3; i++) expect_rd("rx byte", REG_RXDATA, {8'h00, b[i]});
    expect_rd("rx drained", REG_RXCOUNT, 16'h0000);
    $display("test rx done");
  endtask : t_rx
  task automatic t_wrap();
    wr(REG_ILEN, 16'h0003);
    wr(REG_FLUSH, 16'h0001);
    wr(REG_TXDATA, 16'h007e);
    wr(REG_TXGO, 16'h0001);
    for (int i = 0; i < 6; i++) peer.send_byte(8'h10 + 8'(i));
    expect_tx(8'h7e, 1'b1);
    repeat (40) @(posedge sys_clk);
    expect_rd("full count", REG_RXCOUNT, 16'h0004);
    for (int i = 2; i < 6; i++) expect_rd("wrap byte", REG_RXDATA, 16'h0010 + 16'(i));
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_frame();
    wr(REG_FLUSH, 16'h0001);
    wr(REG_ISTAT, 16'h000f);
    wr(REG_CTRL, 16'h00bf);
    peer.send_byte(8'hc3);
    peer.send_byte(8'h43);
    repeat (40) @(posedge sys_clk);
    expect_rd("seven count", REG_RXCOUNT, 16'h0002);
    for (int i = 0; i < 2; i++) expect_rd("seven byte", REG_RXDATA, 16'h0043);
    expect_rd("parity flag", REG_ISTAT, 16'h0005);
    wr(REG_CTRL, 16'h01df);
    wr(REG_TXDATA, 16'h005b);
    wr(REG_TXGO, 16'h0001);
    expect_tx(8'h5b, 1'b0);
    $display("test frame done");
  endtask : t_frame
  task automatic t_close();
    wr(REG_FLUSH, 16'h0001);
    wr(REG_CTRL, 16'h001e);
    peer.send_byte(8'h66);
    repeat (40) @(posedge sys_clk);
    expect_rd("closed", REG_RXCOUNT, 16'h0000);
    wr(REG_CTRL, 16'h001f);
    peer.send_byte(8'h99);
    repeat (40) @(posedge sys_clk);
    expect_rd("reopened", REG_RXCOUNT, 16'h0001);
    $display("test close done");
  endtask : t_close
  // ==========================================================================
  // Verdict.
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    rst_n     <= 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_wrap();
    t_frame();
    t_close();
    report_and_stop();
  end
endmodule : uart_dma_ring_buffer_port_tb_top

// ### test/udr_port_props.sv
// Purpose: Port assertions for the ring-buffer serial port.
// Assumes: Register strobes are one cycle long.
// Notes:   Attached to udr_port by bind.
`timescale 1ns/1ps
module udr_port_props import udr_pkg::*; (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        irq
);
  // ==========================================================================
  // Helper state: cycles since txd last moved, and whether sending was started.
  logic [7:0] run;
  logic       last;
  logic       go_seen;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run  <= 8'h00;
      last <= 1'b1;
    end else begin
      last <= txd;
      run  <= (txd != last) ? 8'h00 : ((run == 8'hff) ? run : run + 8'h01);
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) go_seen <= 1'b0;
    else if (reg_wr && reg_addr == REG_TXGO && reg_wdata[0]) go_seen <= 1'b1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Assertions.
  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (reg_rd && reg_addr > REG_FLUSH
    |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  count_range_a: assert property (reg_rd && reg_addr == REG_RXCOUNT
    |=> reg_rdata <= 16'h0010)
    else $error("receive count out of range");
  pop_byte_a: assert property (reg_rd && reg_addr == REG_RXDATA
    |=> reg_rdata[15:8] == 8'h00)
    else $error("receive data wider than a byte");
  status_res_a: assert property (reg_rd && reg_addr == REG_STATUS
    |=> reg_rdata[3] == 1'b0 && reg_rdata[15:12] == 4'h0)
    else $error("status reserved bits set");
  bit_width_a: assert property ((txd != last) |-> run >= 8'h0f)
    else $error("serial bit shorter than sixteen clocks");
  tx_quiet_a: assert property (!go_seen |-> txd)
    else $error("txd left idle before sending started");
  irq_mask_a: assert property (reg_wr && reg_addr == REG_IMASK && reg_wdata[3:0] == 4'h0
    ##1 !(reg_wr && reg_addr == REG_IMASK) |-> ##1 !irq)
    else $error("irq high with all sources masked");
endmodule : udr_port_props

bind udr_port udr_port_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rxd(rxd), .txd(txd), .irq(irq));

// ### test/udr_serial_peer.sv
// Purpose: Remote serial device that sends frames and captures what it hears.
// Assumes: Frames of 8 data bits, LSB first, one stop bit.
// Notes:   Never asks the port to pause the stream.
`timescale 1ns/1ps
module udr_serial_peer #(parameter int BIT_CYC = 16) (
  input  wire logic sys_clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [8:0] got_q[$];
  initial rxd = 1'b1;
  // ==========================================================================
  // Send one frame; the line rests high between frames.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      rxd <= f[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
  endtask : send_byte
  // ==========================================================================
  // Capture frames mid-bit; the stop level is kept in bit 8.
  initial begin : capture
    logic [8:0] b;
    forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(posedge sys_clk);
        b[i] = txd;
      end
      got_q.push_back(b);
    end
  end
endmodule : udr_serial_peer
